//--- logic/ccr_charger_config.sv
/*
  Charger configuration register bank with its safety timer control,
  termination latch, timeout flags and a masked event interrupt.
  Assumes a plain register port master with one-cycle strobes, and that the
  analog charger reports precharge phase, loop activity and termination
  current as levels synchronous to clk_in.
*/
`timescale 1ns/1ps
module ccr_charger_config #(
  parameter int TICK_CYCLES = ccr_pkg::TICK_CYCLES,
  parameter int PRECHG_MIN_SEL0 = ccr_pkg::PRECHG_MIN_SEL0,
  parameter int PRECHG_MIN_SEL1 = ccr_pkg::PRECHG_MIN_SEL1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic precharge_phase_in,
  input wire logic thermal_loop_in,
  input wire logic input_power_limit_loop_in,
  input wire logic term_current_reached_in,
  output logic charging_active_out,
  output logic charger_reset_out,
  output logic thermistor_curve_select_out,
  output logic current_term_enable_out,
  output logic precharge_threshold_select_out,
  output logic [1:0] regulation_voltage_select_out,
  output logic [1:0] charge_current_select_out,
  output logic [1:0] power_path_threshold_out,
  output logic precharge_time_select_out,
  output logic [1:0] term_current_select_out,
  output logic temperature_range_select_out,
  output logic charge_timer_expired_out,
  output logic precharge_timer_expired_out,
  output logic irq_out
);

  // ----------------------------------------------------------------------
  // Register storage and decode.
  // ----------------------------------------------------------------------
  logic [7:0] timer_en_ctrl_q;
  logic [7:0] volt_rate_ctrl_q;
  logic [7:0] curr_thr_ctrl_q;
  logic [7:0] event_mask_q;
  logic [ccr_pkg::EVT_COUNT-1:0] event_status_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] chg_status;
  logic wr_timer_en;
  logic wr_volt_rate;
  logic wr_curr_thr;
  logic wr_mask;
  logic rd_events;

  assign wr_timer_en = wr_in && (addr_in == ccr_pkg::ADDR_TIMER_EN_CTRL);
  assign wr_volt_rate = wr_in && (addr_in == ccr_pkg::ADDR_VOLT_RATE_CTRL);
  assign wr_curr_thr = wr_in && (addr_in == ccr_pkg::ADDR_CURR_THR_CTRL);
  assign wr_mask = wr_in && (addr_in == ccr_pkg::ADDR_EVENT_MASK);
  assign rd_events = rd_in && (addr_in == ccr_pkg::ADDR_EVENT_STATUS);

  // Timer and enable controls; restart is plain storage, the host pulses it.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_en_ctrl_q <= ccr_pkg::RST_TIMER_EN_CTRL;
    end else if (wr_timer_en) begin
      timer_en_ctrl_q <= wdata_in;
    end
  end

  // Voltage and rate controls, spare bits stored as written.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      volt_rate_ctrl_q <= ccr_pkg::RST_VOLT_RATE_CTRL;
    end else if (wr_volt_rate) begin
      volt_rate_ctrl_q <= wdata_in;
    end
  end

  // Current and threshold controls.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      curr_thr_ctrl_q <= ccr_pkg::RST_CURR_THR_CTRL;
    end else if (wr_curr_thr) begin
      curr_thr_ctrl_q <= wdata_in;
    end
  end

  // Event mask: a one lets the event reach the interrupt.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      event_mask_q <= ccr_pkg::RST_EVENT_MASK;
    end else if (wr_mask) begin
      event_mask_q <= wdata_in;
    end
  end

  // ----------------------------------------------------------------------
  // Field extraction.
  // ----------------------------------------------------------------------
  logic [1:0] fast_time_code;
  logic timers_on;
  logic restart;
  logic term_skip;
  logic timers_hold;
  logic charger_on;
  logic half_rate;

  assign fast_time_code = timer_en_ctrl_q[ccr_pkg::FLD_FAST_TIME_LSB +: 2];
  assign timers_on = timer_en_ctrl_q[ccr_pkg::FLD_SAFETY_TIMERS_ON];
  assign restart = timer_en_ctrl_q[ccr_pkg::FLD_CHARGER_RESTART];
  assign term_skip = timer_en_ctrl_q[ccr_pkg::FLD_TERM_SKIP];
  assign timers_hold = timer_en_ctrl_q[ccr_pkg::FLD_TIMERS_HOLD];
  assign charger_on = timer_en_ctrl_q[ccr_pkg::FLD_CHARGER_ON];
  assign half_rate = volt_rate_ctrl_q[ccr_pkg::FLD_HALF_RATE];

  // Selections passed straight to the analog charger; the termination enable is the skip bit inverted.
  assign thermistor_curve_select_out = timer_en_ctrl_q[ccr_pkg::FLD_THERMISTOR_CURVE];
  assign current_term_enable_out = !term_skip;
  assign precharge_threshold_select_out = volt_rate_ctrl_q[ccr_pkg::FLD_PRECHG_THRESHOLD];
  assign regulation_voltage_select_out = volt_rate_ctrl_q[ccr_pkg::FLD_REG_VOLT_LSB +: 2];
  assign charge_current_select_out = curr_thr_ctrl_q[ccr_pkg::FLD_CHG_CURRENT_LSB +: 2];
  assign power_path_threshold_out = curr_thr_ctrl_q[ccr_pkg::FLD_POWER_PATH_THR_LSB +: 2];
  assign precharge_time_select_out = curr_thr_ctrl_q[ccr_pkg::FLD_PRECHG_TIME];
  assign term_current_select_out = curr_thr_ctrl_q[ccr_pkg::FLD_TERM_CURRENT_LSB +: 2];
  assign temperature_range_select_out = curr_thr_ctrl_q[ccr_pkg::FLD_TEMP_RANGE];
  assign charger_reset_out = restart;

  // ----------------------------------------------------------------------
  // Timer limits and the one-second tick.
  // ----------------------------------------------------------------------
  logic [ccr_pkg::TIMER_W-1:0] fast_limit;
  logic [ccr_pkg::TIMER_W-1:0] prechg_limit;
  logic [31:0] tick_cnt_q;
  logic tick;

  // Limits in seconds from the selected durations.
  always_comb begin
    unique case (fast_time_code)
      2'h0: fast_limit = ccr_pkg::TIMER_W'(ccr_pkg::FAST_HOURS_CODE0 * ccr_pkg::SEC_PER_HOUR);
      2'h1: fast_limit = ccr_pkg::TIMER_W'(ccr_pkg::FAST_HOURS_CODE1 * ccr_pkg::SEC_PER_HOUR);
      2'h2: fast_limit = ccr_pkg::TIMER_W'(ccr_pkg::FAST_HOURS_CODE2 * ccr_pkg::SEC_PER_HOUR);
      2'h3: fast_limit = ccr_pkg::TIMER_W'(ccr_pkg::FAST_HOURS_CODE3 * ccr_pkg::SEC_PER_HOUR);
    endcase
  end

  assign prechg_limit = precharge_time_select_out ? ccr_pkg::TIMER_W'(PRECHG_MIN_SEL1 * ccr_pkg::SEC_PER_MIN) :
                                                    ccr_pkg::TIMER_W'(PRECHG_MIN_SEL0 * ccr_pkg::SEC_PER_MIN);

  // Free-running prescaler; both timers share it, so a restart may cost
  // up to one second of timer accuracy in exchange for a single counter.
  always_ff @(posedge clk_in) begin
    if (reset_in || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Safety timers.
  // ----------------------------------------------------------------------
  logic timer_clear;
  logic timer_slow;
  logic prechg_run;
  logic fast_run;
  logic prechg_expired;
  logic fast_expired;
  logic term_done_q;
  logic charge_timeout_q;
  logic prechg_timeout_q;

  // Any of these puts both timers back to zero.
  assign timer_clear = !timers_on || restart || !charger_on;
  assign timer_slow = half_rate && (thermal_loop_in || input_power_limit_loop_in);
  assign prechg_run = charging_active_out && precharge_phase_in;
  assign fast_run = charging_active_out && !precharge_phase_in;

  ccr_safety_timer u_prechg_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(tick),
    .clear_in(timer_clear),
    .run_in(prechg_run),
    .hold_in(timers_hold),
    .slow_in(timer_slow),
    .limit_in(prechg_limit),
    .expired_out(prechg_expired)
  );

  ccr_safety_timer u_fast_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(tick),
    .clear_in(timer_clear),
    .run_in(fast_run),
    .hold_in(timers_hold),
    .slow_in(timer_slow),
    .limit_in(fast_limit),
    .expired_out(fast_expired)
  );

  // Timeout flags stay until restart or disable; expiry of either timer
  // raises the charge flag, precharge expiry raises its own as well.
  always_ff @(posedge clk_in) begin
    if (reset_in || restart || !charger_on) begin
      charge_timeout_q <= 1'b0;
      prechg_timeout_q <= 1'b0;
    end else begin
      if (prechg_expired || fast_expired) begin
        charge_timeout_q <= 1'b1;
      end
      if (prechg_expired) begin
        prechg_timeout_q <= 1'b1;
      end
    end
  end

  // Current termination latch, only armed when it is not skipped.
  always_ff @(posedge clk_in) begin
    if (reset_in || restart || !charger_on) begin
      term_done_q <= 1'b0;
    end else if (!term_skip && term_current_reached_in && charging_active_out && !precharge_phase_in) begin
      term_done_q <= 1'b1;
    end
  end

  // Charging stops on disable, restart, timeout or termination.
  assign charging_active_out = charger_on && !restart && !charge_timeout_q && !term_done_q;
  assign charge_timer_expired_out = charge_timeout_q;
  assign precharge_timer_expired_out = prechg_timeout_q;

  // ----------------------------------------------------------------------
  // Events and interrupt.
  // ----------------------------------------------------------------------
  logic [ccr_pkg::EVT_COUNT-1:0] event_src_q;
  logic [ccr_pkg::EVT_COUNT-1:0] event_src;
  logic [ccr_pkg::EVT_COUNT-1:0] event_rise;

  assign event_src[ccr_pkg::EVT_CHARGE_TIMEOUT] = charge_timeout_q;
  assign event_src[ccr_pkg::EVT_PRECHG_TIMEOUT] = prechg_timeout_q;
  assign event_src[ccr_pkg::EVT_TERM_DONE] = term_done_q;

  // Previous source levels for edge detection.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      event_src_q <= '0;
    end else begin
      event_src_q <= event_src;
    end
  end

  // Sticky bits cleared by a read; a new event in the read cycle survives.
  genvar gi;
  generate
    for (gi = 0; gi < ccr_pkg::EVT_COUNT; gi++) begin : g_event
      assign event_rise[gi] = event_src[gi] && !event_src_q[gi];
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          event_status_q[gi] <= 1'b0;
        end else if (event_rise[gi]) begin
          event_status_q[gi] <= 1'b1;
        end else if (rd_events) begin
          event_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_out = |(event_status_q & event_mask_q[ccr_pkg::EVT_COUNT-1:0]);

  // ----------------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------------
  always_comb begin
    chg_status = 8'h00;
    chg_status[ccr_pkg::STS_TERM_DONE] = term_done_q;
    chg_status[ccr_pkg::STS_ACTIVE] = charging_active_out;
    chg_status[ccr_pkg::STS_CHARGE_TIMEOUT] = charge_timeout_q;
    chg_status[ccr_pkg::STS_PRECHG_TIMEOUT] = prechg_timeout_q;
  end

  // Unmapped addresses read as zero.
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr_in)
      ccr_pkg::ADDR_CHG_STATUS: rdata_d = chg_status;
      ccr_pkg::ADDR_TIMER_EN_CTRL: rdata_d = timer_en_ctrl_q;
      ccr_pkg::ADDR_VOLT_RATE_CTRL: rdata_d = volt_rate_ctrl_q;
      ccr_pkg::ADDR_CURR_THR_CTRL: rdata_d = curr_thr_ctrl_q;
      ccr_pkg::ADDR_EVENT_STATUS: rdata_d = {{(8 - ccr_pkg::EVT_COUNT){1'b0}}, event_status_q};
      ccr_pkg::ADDR_EVENT_MASK: rdata_d = event_mask_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_in) begin
    if (reset_in || !rd_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  a_reset_values: assert property (@(posedge clk_in) ($past(reset_in) && !reset_in) |->
    timer_en_ctrl_q == 8'hB1 && volt_rate_ctrl_q == 8'h80 && curr_thr_ctrl_q == 8'hB2)
    else $error("control registers not at reset values");

  a_write_readback: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_in && addr_in == 8'h05) ##1 (rd_in && addr_in == 8'h05) |=> rdata_out == $past(wdata_in, 2))
    else $error("second control register readback wrong");

  a_restart_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    restart |-> charger_reset_out && !charging_active_out)
    else $error("restart bit did not hold charger in reset");

  a_enable_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    !charger_on |-> !charging_active_out ##1 !charge_timeout_q)
    else $error("charger active while disabled");

  a_term_skip: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(term_done_q) |-> $past(!term_skip && term_current_reached_in))
    else $error("termination latched while skipped");

  a_prechg_flags: assert property (@(posedge clk_in) disable iff (reset_in)
    (prechg_expired && charger_on && !restart) |=> prechg_timeout_q && charge_timeout_q ##0 !charging_active_out)
    else $error("precharge expiry flags missing");

  a_timer_off: assert property (@(posedge clk_in) disable iff (reset_in)
    !timers_on [*2] |-> !prechg_expired && !fast_expired)
    else $error("timer expired while disabled");

  a_event_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    (rd_events && event_rise == '0) |=> event_status_q == '0 ##0 !irq_out)
    else $error("event status not cleared by read");

  a_fast_limit: assert property (@(posedge clk_in) disable iff (reset_in)
    fast_time_code == 2'h3 |-> fast_limit == 16'h7080)
    else $error("eight hour limit wrong");

endmodule

//--- logic/ccr_pkg.sv
/*
  Shared constants of the charger configuration register bank: register
  addresses, field positions, reset values and timing figures.
  Assumes a single 100 MHz logic clock and an 8-bit register port.
*/
package ccr_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the plain register port.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CHG_STATUS = 8'h03;
  localparam logic [7:0] ADDR_TIMER_EN_CTRL = 8'h04;
  localparam logic [7:0] ADDR_VOLT_RATE_CTRL = 8'h05;
  localparam logic [7:0] ADDR_CURR_THR_CTRL = 8'h06;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h11;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_TIMER_EN_CTRL = 8'hB1;
  localparam logic [7:0] RST_VOLT_RATE_CTRL = 8'h80;
  localparam logic [7:0] RST_CURR_THR_CTRL = 8'hB2;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions of the timer and enable control register.
  // ----------------------------------------------------------------------
  localparam int FLD_FAST_TIME_LSB = 6;
  localparam int FLD_SAFETY_TIMERS_ON = 5;
  localparam int FLD_THERMISTOR_CURVE = 4;
  localparam int FLD_CHARGER_RESTART = 3;
  localparam int FLD_TERM_SKIP = 2;
  localparam int FLD_TIMERS_HOLD = 1;
  localparam int FLD_CHARGER_ON = 0;

  // ----------------------------------------------------------------------
  // Field positions of the voltage and timer rate control register.
  // ----------------------------------------------------------------------
  localparam int FLD_HALF_RATE = 7;
  localparam int FLD_PRECHG_THRESHOLD = 6;
  localparam int FLD_REG_VOLT_LSB = 4;
  localparam int FLD_SPARE_LSB = 0;

  // ----------------------------------------------------------------------
  // Field positions of the current and threshold control register.
  // ----------------------------------------------------------------------
  localparam int FLD_CHG_CURRENT_LSB = 6;
  localparam int FLD_POWER_PATH_THR_LSB = 4;
  localparam int FLD_PRECHG_TIME = 3;
  localparam int FLD_TERM_CURRENT_LSB = 1;
  localparam int FLD_TEMP_RANGE = 0;

  // ----------------------------------------------------------------------
  // Status and event bits.
  // ----------------------------------------------------------------------
  localparam int STS_TERM_DONE = 4;
  localparam int STS_ACTIVE = 3;
  localparam int STS_CHARGE_TIMEOUT = 2;
  localparam int STS_PRECHG_TIMEOUT = 1;
  localparam int EVT_CHARGE_TIMEOUT = 0;
  localparam int EVT_PRECHG_TIMEOUT = 1;
  localparam int EVT_TERM_DONE = 2;
  localparam int EVT_COUNT = 3;

  // ----------------------------------------------------------------------
  // Timing: the safety timers count one-second ticks.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SEC_PER_HOUR = 3600;
  localparam int SEC_PER_MIN = 60;
  localparam int FAST_HOURS_CODE0 = 4;
  localparam int FAST_HOURS_CODE1 = 5;
  localparam int FAST_HOURS_CODE2 = 6;
  localparam int FAST_HOURS_CODE3 = 8;
  localparam int PRECHG_MIN_SEL0 = 30;
  localparam int PRECHG_MIN_SEL1 = 60;
  localparam int TIMER_W = 16;

endpackage

//--- logic/ccr_safety_timer.sv
/*
  One safety timer: counts one-second ticks up to a limit and flags expiry.
  Assumes tick_in is a one-cycle pulse and limit_in is steady while running.
*/
`timescale 1ns/1ps
module ccr_safety_timer (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic hold_in,
  input wire logic slow_in,
  input wire logic [ccr_pkg::TIMER_W-1:0] limit_in,
  output logic expired_out
);

  logic [ccr_pkg::TIMER_W-1:0] count_q;
  logic phase_q;
  logic advance;

  // Half rate takes every second tick; hold freezes count and phase alike.
  assign advance = tick_in && run_in && !hold_in && (!slow_in || phase_q) && !expired_out;

  // Phase of the half-rate divider.
  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      phase_q <= 1'b0;
    end else if (tick_in && run_in && !hold_in && slow_in) begin
      phase_q <= !phase_q;
    end
  end

  // Elapsed seconds; cleared whenever the timer is disabled.
  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      count_q <= '0;
    end else if (advance) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Expiry is sticky until the timer is cleared.
  always_ff @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      expired_out <= 1'b0;
    end else if (run_in && (count_q >= limit_in)) begin
      expired_out <= 1'b1;
    end
  end

  a_hold_count: assert property (@(posedge clk_in) disable iff (reset_in)
    (hold_in && !clear_in) |=> $stable(count_q))
    else $error("timer advanced while held");

  a_clear_count: assert property (@(posedge clk_in) disable iff (reset_in)
    clear_in |=> (count_q == '0) && !expired_out)
    else $error("timer not cleared");

endmodule

//--- tb/tb.sv
/*
  Self-checking bench for the charger configuration register bank.
  Assumes short tick and precharge parameters so the timers expire quickly.
*/
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic prech_in = 1'b0;
  logic therm_in = 1'b0;
  logic term_in = 1'b0;
  logic ppl_in = 1'b0;
  logic [7:0] rdata_out, v;
  logic act_out, rst_out, ntc_out, term_en_out, thr_out, pt_out, tr_out, ctmo_out, ptmo_out, irq_out;
  logic [1:0] volt_out, cur_out, pp_out, ti_out;
  int fails = 0;
  int num_checks = 0;
  int i;

  ccr_charger_config #(.TICK_CYCLES(4), .PRECHG_MIN_SEL0(1), .PRECHG_MIN_SEL1(1)) i_ccr_charger_config (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .precharge_phase_in(prech_in), .thermal_loop_in(therm_in),
    .input_power_limit_loop_in(ppl_in), .term_current_reached_in(term_in), .charging_active_out(act_out),
    .charger_reset_out(rst_out), .thermistor_curve_select_out(ntc_out), .current_term_enable_out(term_en_out),
    .precharge_threshold_select_out(thr_out), .regulation_voltage_select_out(volt_out),
    .charge_current_select_out(cur_out), .power_path_threshold_out(pp_out), .precharge_time_select_out(pt_out),
    .term_current_select_out(ti_out), .temperature_range_select_out(tr_out),
    .charge_timer_expired_out(ctmo_out), .precharge_timer_expired_out(ptmo_out), .irq_out(irq_out));

  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  // Compares one value; widths are padded to a byte and !== lets no unknown match.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: strobe, address and data stand for one edge. The strobe is left up
  // so a second access may follow with no gap; idle or rd lowers it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
  endtask

  // Lowers the write strobe and lets one edge pass, so outputs have settled.
  task automatic idle();
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken
  // at the falling edge inside that cycle, well away from either launch.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs about 1,200 cycles; this allows 20,000.
  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    idle();
    // ------------------------------------------------------------
    // Reset values and output defaults.
    // ------------------------------------------------------------
    rd(8'h04, v);
    chk(v, 8'hB1);
    rd(8'h05, v);
    chk(v, 8'h80);
    rd(8'h06, v);
    chk(v, 8'hB2);
    rd(8'h11, v);
    chk(v, 8'h00);
    chk({act_out, rst_out, ntc_out, term_en_out, cur_out, irq_out, 1'b0}, 8'hB8);
    $display("test reset done");
    // ------------------------------------------------------------
    // Read-back, field outputs, refused and unmapped places.
    // ------------------------------------------------------------
    wr(8'h06, 8'h5D);
    rd(8'h06, v);
    chk(v, 8'h5D);
    chk({cur_out, pp_out, pt_out, ti_out, tr_out}, 8'h5D);
    wr(8'h05, 8'h7A);
    rd(8'h05, v);
    chk(v, 8'h7A);
    chk({5'h00, thr_out, volt_out}, 8'h07);
    wr(8'h04, 8'hCE);
    rd(8'h04, v);
    chk(v, 8'hCE);
    chk({4'h0, act_out, rst_out, ntc_out, term_en_out}, 8'h04);
    wr(8'h04, 8'hB1);
    wr(8'h05, 8'h80);
    wr(8'h06, 8'hB2);
    wr(8'h03, 8'hFF);
    rd(8'h03, v);
    chk(v, 8'h08);
    rd(8'h20, v);
    chk(v, 8'h00);
    $display("test readback done");
    // ------------------------------------------------------------
    // Timer hold, half rate under regulation, precharge expiry.
    // ------------------------------------------------------------
    wr(8'h11, 8'h07);
    wr(8'h04, 8'hB3);
    idle();
    prech_in <= 1'b1;
    therm_in <= 1'b1;
    // Long enough to expire even at half rate if the hold were ignored.
    repeat (600) @(posedge clk_in);
    chk({6'h00, ctmo_out, ptmo_out}, 8'h00);
    wr(8'h04, 8'hB1);
    idle();
    therm_in <= 1'b0;
    ppl_in <= 1'b1;
    // Long enough to expire at nominal rate, too short at half rate.
    repeat (300) @(posedge clk_in);
    chk({6'h00, ctmo_out, ptmo_out}, 8'h00);
    for (i = 0; i < 400 && ptmo_out !== 1'b1; i++) begin
      @(negedge clk_in);
    end
    chk({5'h00, act_out, ctmo_out, ptmo_out}, 8'h03);
    @(negedge clk_in);
    chk({7'h00, irq_out}, 8'h01);
    @(posedge clk_in);
    rd(8'h10, v);
    chk(v, 8'h03);
    chk({7'h00, irq_out}, 8'h00);
    wr(8'h04, 8'hB9);
    idle();
    chk({6'h00, rst_out, act_out}, 8'h02);
    wr(8'h04, 8'hB1);
    idle();
    chk({5'h00, act_out, ctmo_out, ptmo_out}, 8'h04);
    $display("test timers done");
    // ------------------------------------------------------------
    // Current-based termination skipped, then taken.
    // ------------------------------------------------------------
    prech_in <= 1'b0;
    ppl_in <= 1'b0;
    wr(8'h04, 8'hB5);
    idle();
    term_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk({6'h00, act_out, term_en_out}, 8'h02);
    wr(8'h04, 8'hB1);
    idle();
    repeat (3) @(posedge clk_in);
    chk({6'h00, act_out, irq_out}, 8'h01);
    rd(8'h10, v);
    chk(v, 8'h04);
    wr(8'h04, 8'hB0);
    idle();
    chk({7'h00, act_out}, 8'h00);
    $display("test termination done");
    // ------------------------------------------------------------
    // Reset again in mid-run: written values must give way.
    // ------------------------------------------------------------
    reset_in <= 1'b1;
    term_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    idle();
    rd(8'h04, v);
    chk(v, 8'hB1);
    rd(8'h11, v);
    chk(v, 8'h00);
    chk({act_out, ctmo_out, irq_out, 5'h00}, 8'h80);
    $display("test second reset done");
    stop_test();
  end
endmodule
